// ### hdl/codec_ctrl_pkg.sv
package codec_ctrl_pkg;

  // control register indices, carried in word bits 10..8
  localparam logic [2:0] SERIAL_MODE_CONTROL = 3'h0;
  localparam logic [2:0] CLOCK_RATE_CONTROL  = 3'h1;
  localparam logic [2:0] POWER_CONTROL       = 3'h2;
  localparam logic [2:0] GAIN_SELECT_CONTROL = 3'h3;
  localparam logic [2:0] DAC_TIMING_CONTROL  = 3'h4;
  localparam logic [2:0] ANALOG_TAP_CONTROL  = 3'h5;
  localparam logic [2:0] DIGITAL_TAP_LOW     = 3'h6;
  localparam logic [2:0] DIGITAL_TAP_HIGH    = 3'h7;
  localparam int         NUM_REGS            = 8;
  localparam logic [7:0] REG_RESET           = 8'h00;

  // serial_mode_control field positions
  localparam int OPERATING_MODE_BIT   = 0;
  localparam int MIXED_MODE_BIT       = 1;
  localparam int DIGITAL_LOOPBACK_BIT = 2;
  localparam int PORT_LOOPBACK_BIT    = 3;
  localparam int DEVICE_COUNT_LSB     = 4;
  localparam int SOFT_RESET_BIT       = 7;

  // clock_rate_control field positions
  localparam int SAMPLE_RATE_LSB   = 0;
  localparam int SERIAL_DIVIDE_LSB = 2;
  localparam int MASTER_DIVIDE_LSB = 4;

  // dac_timing_control field position and width
  localparam int DAC_ADVANCE_LSB = 0;
  localparam int DAC_ADVANCE_W   = 5;

  // master divide codes above this one fall back to divide by one
  localparam logic [2:0] MASTER_DIVIDE_MAX_CODE = 3'h4;

  // timing in device master clock cycles
  localparam logic [11:0] SLOWEST_SAMPLE_PERIOD = 12'h800;
  localparam int          ADVANCE_STEP_SHIFT    = 5;
  localparam logic [2:0]  SOFT_RESET_CYCLES     = 3'h4;

  // 16-bit control word as it arrives on the serial port
  typedef struct packed {
    logic       is_control;
    logic       is_read;
    logic [2:0] dev_addr;
    logic [2:0] reg_addr;
    logic [7:0] data;
  } control_word_t;

endpackage

// ### hdl/codec_control_word_clock_dividers.sv
`timescale 1ns/1ps
`default_nettype none

// Operation
// RQ1 - master divide field divides by one to five
// RQ2 - serial divide field selects divide 8/4/2/1
// RQ3 - serial clock slowest after reset
// RQ4 - sample rate field selects 2048/1024/512/256
// RQ5 - sample interval slowest after reset
// RQ6 - dac load one serial clock before sync
// RQ7 - advance field moves load by 1/32 steps
// RQ8 - software changes advance only with dac down
// RQ9 - bit 15 separates control, data, invalid
// RQ10 - write data field when addressed here
// RQ11 - read places register into word, shifts out
// RQ12 - nonzero address decremented and passed on
// RQ13 - bits 10..8 select one of eight registers
// RQ14 - bits 7..0 carry write or read data
// RQ15 - mode bit 0 selects program or data
// RQ16 - mode bit 1 enables mixed mode
// RQ17 - mode bit 2 enables digital loopback
// RQ18 - mode bit 3 enables port loopback
// RQ19 - mode bits 4..6 hold device count
// RQ20 - writing mode bit 7 starts software reset
// RQ21 - registers update on serial clock falling edge
// RQ22 - both resets zero registers, four cycles
// RQ23 - first frame sync 2048 cycles after reset
// RQ24 - mixed mode msb flags control, 15 data bits
module codec_control_word_clock_dividers (
  input  wire logic                          i_core_clk,         // external master clock
  input  wire logic                          i_rst_n,            // reset pin, async low
  input  wire logic                          i_word_valid,       // received word strobe
  input  wire codec_ctrl_pkg::control_word_t i_word,             // received 16-bit word
  output logic                               o_word_ready,       // no word pending
  output logic                               o_out_valid,        // outgoing word strobe
  output logic [15:0]                        o_out_word,         // read back or forwarded
  output logic                               o_dac_valid,        // dac data word strobe
  output logic [15:0]                        o_dac_word,         // dac data, msb aligned
  output logic                               o_invalid_word,     // bad word in program mode
  output logic                               o_device_master_clock_tick,       // device master clock pulse
  output logic                               o_sclk_fall,        // serial clock falling pulse
  output logic                               o_frame_sync,       // output frame sync pulse
  output logic                               o_dac_load,         // dac load event pulse
  output logic                               o_operating_mode,   // 1 = data mode
  output logic                               o_mixed_mode,       // mixed program and data
  output logic                               o_digital_loopback, // converter loopback
  output logic                               o_port_loopback,    // serial port loopback
  output logic [2:0]                         o_device_count,     // cascade device count
  output logic                               o_soft_reset_busy,  // software reset running
  output logic [7:0]                         o_power_control,    // power register contents
  output logic [7:0]                         o_gain_select,      // gain register contents
  output logic [7:0]                         o_dac_timing,       // dac timing register
  output logic [7:0]                         o_analog_tap,       // analog tap register
  output logic [15:0]                        o_digital_tap       // digital tap, high:low
);

  // register file
  logic [7:0]  regs [codec_ctrl_pkg::NUM_REGS];   // eight control registers

  // pending word, applied at the next serial falling edge
  logic                          pending;         // word waiting for the edge
  codec_ctrl_pkg::control_word_t held;            // the waiting word

  // clock generation
  logic [2:0]  mdiv_cnt;                          // master divide counter
  logic [2:0]  mdiv_last;                         // terminal count of master divide
  logic        device_master_clock_tick;                        // one pulse per device master cycle
  logic [2:0]  sdiv_cnt;                          // serial divide counter
  logic [3:0]  sclk_div;                          // serial clock period in device_master_clock cycles
  logic        sclk_fall;                         // serial clock falling edge
  logic [11:0] sample_cnt;                        // position within sample interval
  logic [11:0] sample_period;                     // device_master_clock cycles per sample
  logic [11:0] load_pos;                          // count at which dac is loaded
  logic [4:0]  advance;                           // dac advance in 1/32 steps

  // software reset
  logic [2:0]  srst_cnt;                          // remaining device_master_clock cycles of reset
  logic        srst_busy;                         // software reset in progress
  logic        srst_start;                        // write of 1 into mode bit 7

  // word decode
  logic        addressed;                         // device address field is zero
  logic        data_mode;                         // operating mode bit
  logic        mixed;                             // mixed mode bit
  logic        apply;                             // word is acted on this cycle

  // field views of the two clocking registers
  logic [2:0]  master_code;                       // master divide field
  logic [1:0]  serial_code;                       // serial divide field
  logic [1:0]  rate_code;                         // sample rate field

  assign master_code = regs[codec_ctrl_pkg::CLOCK_RATE_CONTROL][codec_ctrl_pkg::MASTER_DIVIDE_LSB +: 3];
  assign serial_code = regs[codec_ctrl_pkg::CLOCK_RATE_CONTROL][codec_ctrl_pkg::SERIAL_DIVIDE_LSB +: 2];
  assign rate_code   = regs[codec_ctrl_pkg::CLOCK_RATE_CONTROL][codec_ctrl_pkg::SAMPLE_RATE_LSB +: 2];
  assign advance     = regs[codec_ctrl_pkg::DAC_TIMING_CONTROL][codec_ctrl_pkg::DAC_ADVANCE_LSB +:
                         codec_ctrl_pkg::DAC_ADVANCE_W];
  assign data_mode   = regs[codec_ctrl_pkg::SERIAL_MODE_CONTROL][codec_ctrl_pkg::OPERATING_MODE_BIT];
  assign mixed       = regs[codec_ctrl_pkg::SERIAL_MODE_CONTROL][codec_ctrl_pkg::MIXED_MODE_BIT];

  // master divide terminal count; illegal codes fall back to one
  always_comb begin
    if (master_code <= codec_ctrl_pkg::MASTER_DIVIDE_MAX_CODE) begin
      mdiv_last = master_code;                     // RQ1
    end else begin
      mdiv_last = 3'h0;                            // RQ1
    end
  end

  // master divider runs even during software reset so it can be timed
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mdiv_cnt <= 3'h0;
    end else if (mdiv_cnt >= mdiv_last) begin
      mdiv_cnt <= 3'h0;                            // RQ1
    end else begin
      mdiv_cnt <= mdiv_cnt + 3'h1;
    end
  end

  assign device_master_clock_tick = (mdiv_cnt >= mdiv_last);

  // serial divide: code 0 is slowest, so zeroed registers give /8
  always_comb begin
    unique case (serial_code)
      2'h0:    sclk_div = 4'h8;                    // RQ2 RQ3
      2'h1:    sclk_div = 4'h4;                    // RQ2
      2'h2:    sclk_div = 4'h2;                    // RQ2
      2'h3:    sclk_div = 4'h1;                    // RQ2
    endcase
  end

  // serial clock counter, restarted by either reset
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sdiv_cnt <= 3'h0;
    end else if (srst_busy) begin
      sdiv_cnt <= 3'h0;
    end else if (device_master_clock_tick) begin
      if ({1'b0, sdiv_cnt} >= sclk_div - 4'h1) begin
        sdiv_cnt <= 3'h0;
      end else begin
        sdiv_cnt <= sdiv_cnt + 3'h1;
      end
    end
  end

  assign sclk_fall = device_master_clock_tick && !srst_busy && ({1'b0, sdiv_cnt} >= sclk_div - 4'h1);

  // sample interval; the slowest rate again sits at code 0
  always_comb begin
    unique case (rate_code)
      2'h0:    sample_period = codec_ctrl_pkg::SLOWEST_SAMPLE_PERIOD;        // RQ4 RQ5
      2'h1:    sample_period = codec_ctrl_pkg::SLOWEST_SAMPLE_PERIOD >> 1;   // RQ4
      2'h2:    sample_period = codec_ctrl_pkg::SLOWEST_SAMPLE_PERIOD >> 2;   // RQ4
      2'h3:    sample_period = codec_ctrl_pkg::SLOWEST_SAMPLE_PERIOD >> 3;   // RQ4
    endcase
  end

  // load point: one serial period before sync, less the advance steps;
  // fastest rate with full advance and /8 serial clock goes below zero, so wrap into the interval
  logic [12:0] load_raw;                          // load point before wrapping
  always_comb begin
    load_raw = 13'(sample_period) - 13'h1 - 13'(sclk_div)                    // RQ6
             - 13'(12'(advance) * (sample_period >> codec_ctrl_pkg::ADVANCE_STEP_SHIFT)); // RQ7
    load_pos = load_raw[12] ? load_raw[11:0] + sample_period : load_raw[11:0]; // RQ7
  end

  // sample counter starts at zero after reset, so first sync lands
  // exactly 2048 device master cycles after release
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sample_cnt <= 12'h000;                       // RQ23
    end else if (srst_busy) begin
      sample_cnt <= 12'h000;
    end else if (device_master_clock_tick) begin
      if (sample_cnt >= sample_period - 12'h1) begin
        sample_cnt <= 12'h000;
      end else begin
        sample_cnt <= sample_cnt + 12'h001;
      end
    end
  end

  // sync and load strobes, registered so they are glitch free
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_frame_sync <= 1'b0;
      o_dac_load   <= 1'b0;
    end else begin
      o_frame_sync <= device_master_clock_tick && !srst_busy
                      && (sample_cnt >= sample_period - 12'h1);              // RQ23
      o_dac_load   <= device_master_clock_tick && !srst_busy && (sample_cnt == load_pos);   // RQ6 RQ7
    end
  end

  // the advance field is sampled live; changing it with the dac powered
  // up may skip or double one load, which software is told to avoid
  // (RQ8 binds software, nothing enforced here)

  // software reset lasts four device master cycles
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      srst_cnt <= 3'h0;
    end else if (srst_start) begin
      srst_cnt <= codec_ctrl_pkg::SOFT_RESET_CYCLES;                        // RQ20 RQ22
    end else if (device_master_clock_tick && srst_cnt != 3'h0) begin
      srst_cnt <= srst_cnt - 3'h1;                                           // RQ22
    end
  end

  assign srst_busy = (srst_cnt != 3'h0);

  // word acceptance; one word is held until the serial edge
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pending <= 1'b0;
      held    <= '0;
    end else if (i_word_valid && !pending) begin
      pending <= 1'b1;
      held    <= i_word;
    end else if (apply) begin
      pending <= 1'b0;
    end
  end

  // words wait out a software reset rather than being lost
  assign apply     = pending && sclk_fall;                                   // RQ21
  assign addressed = (held.dev_addr == 3'h0);                                // RQ12

  // a word counts as control only with bit 15 set, and never in plain data mode
  logic is_ctrl;                                   // word is a control word
  logic is_dac;                                    // word is converter data
  always_comb begin
    is_ctrl = 1'b0;
    is_dac  = 1'b0;
    if (!data_mode) begin
      is_ctrl = held.is_control;                   // RQ9 RQ15
    end else if (mixed) begin
      is_ctrl = held.is_control;                   // RQ9 RQ16 RQ24
      is_dac  = !held.is_control;                  // RQ24
    end else begin
      is_dac  = 1'b1;                              // RQ15
    end
  end

  assign srst_start = apply && is_ctrl && addressed && !held.is_read
                      && (held.reg_addr == codec_ctrl_pkg::SERIAL_MODE_CONTROL)
                      && held.data[codec_ctrl_pkg::SOFT_RESET_BIT];           // RQ20

  // register file; software reset clears all, mode bit 7 never stored
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int i = 0; i < codec_ctrl_pkg::NUM_REGS; i++) begin
        regs[i] <= codec_ctrl_pkg::REG_RESET;      // RQ22
      end
    end else if (srst_start || srst_busy) begin
      for (int i = 0; i < codec_ctrl_pkg::NUM_REGS; i++) begin
        regs[i] <= codec_ctrl_pkg::REG_RESET;      // RQ22
      end
    end else if (apply && is_ctrl && addressed && !held.is_read) begin
      regs[held.reg_addr] <= held.data;            // RQ10 RQ13 RQ14
    end
  end

  // outgoing words: read back, forwarded, or flagged invalid
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_out_valid    <= 1'b0;
      o_out_word     <= 16'h0000;
      o_invalid_word <= 1'b0;
      o_dac_valid    <= 1'b0;
      o_dac_word     <= 16'h0000;
    end else begin
      o_out_valid    <= 1'b0;
      o_invalid_word <= 1'b0;
      o_dac_valid    <= 1'b0;
      if (apply && is_ctrl && !addressed) begin
        // pass on toward the next codec with one less hop
        o_out_valid <= 1'b1;
        o_out_word  <= {held.is_control, held.is_read, held.dev_addr - 3'h1,
                        held.reg_addr, held.data};                            // RQ12
      end else if (apply && is_ctrl && held.is_read) begin
        o_out_valid <= 1'b1;
        o_out_word  <= {held.is_control, held.is_read, held.dev_addr,
                        held.reg_addr, regs[held.reg_addr]};                  // RQ11 RQ14
      end else if (apply && is_dac) begin
        // mixed mode loses the flag bit, data is left aligned
        o_dac_valid <= 1'b1;
        o_dac_word  <= mixed ? {held[14:0], 1'b0} : held;                     // RQ24
      end else if (apply && !data_mode && !held.is_control) begin
        o_invalid_word <= 1'b1;                    // RQ9
      end
    end
  end

  // mode and configuration outputs straight from the register file
  assign o_operating_mode   = data_mode;                                      // RQ15
  assign o_mixed_mode       = mixed;                                          // RQ16
  assign o_digital_loopback =
    regs[codec_ctrl_pkg::SERIAL_MODE_CONTROL][codec_ctrl_pkg::DIGITAL_LOOPBACK_BIT]; // RQ17
  assign o_port_loopback    =
    regs[codec_ctrl_pkg::SERIAL_MODE_CONTROL][codec_ctrl_pkg::PORT_LOOPBACK_BIT];    // RQ18
  assign o_device_count     =
    regs[codec_ctrl_pkg::SERIAL_MODE_CONTROL][codec_ctrl_pkg::DEVICE_COUNT_LSB +: 3]; // RQ19
  assign o_power_control    = regs[codec_ctrl_pkg::POWER_CONTROL];
  assign o_gain_select      = regs[codec_ctrl_pkg::GAIN_SELECT_CONTROL];
  assign o_dac_timing       = regs[codec_ctrl_pkg::DAC_TIMING_CONTROL];
  assign o_analog_tap       = regs[codec_ctrl_pkg::ANALOG_TAP_CONTROL];
  assign o_digital_tap      = {regs[codec_ctrl_pkg::DIGITAL_TAP_HIGH],
                               regs[codec_ctrl_pkg::DIGITAL_TAP_LOW]};
  assign o_soft_reset_busy  = srst_busy;
  assign o_device_master_clock_tick       = device_master_clock_tick;
  assign o_sclk_fall        = sclk_fall;
  assign o_word_ready       = !pending;

endmodule

`default_nettype wire

// ### verification/codec_ctrl_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// port-level watch on the control word block
module codec_ctrl_asserts (
  input wire logic       i_core_clk,        // master clock
  input wire logic       i_rst_n,           // async reset, low
  input wire logic       i_word_valid,      // word offered
  input wire logic       o_word_ready,      // no word pending
  input wire logic       o_out_valid,       // word sent on
  input wire logic       o_invalid_word,    // bad word flag
  input wire logic       o_device_master_clock_tick,      // master tick
  input wire logic       o_sclk_fall,       // serial clock fall
  input wire logic       o_frame_sync,      // frame sync
  input wire logic       o_dac_load,        // dac load
  input wire logic       o_operating_mode,  // data mode
  input wire logic       o_soft_reset_busy, // soft reset running
  input wire logic [2:0] o_device_count,    // cascade count
  input wire logic [7:0] o_dac_timing       // advance register
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  // a taken word must block the next one
  ready_drop_a: assert property (i_word_valid && o_word_ready |=> !o_word_ready)
    else $error("word taken but ready stayed high");
  // slowest serial clock is forty core cycles, plus soft reset
  ready_return_a: assert property ($fell(o_word_ready) |-> ##[1:48] o_word_ready)
    else $error("pending word never applied");
  sclk_on_tick_a: assert property (o_sclk_fall |-> o_device_master_clock_tick)
    else $error("serial clock edge off master tick");
  sclk_quiet_a: assert property (o_soft_reset_busy |-> !o_sclk_fall)
    else $error("serial clock ran during soft reset");
  // registers cleared, so master divide is one and busy is four cycles
  busy_len_a: assert property ($rose(o_soft_reset_busy) |-> o_soft_reset_busy[*4] ##1 !o_soft_reset_busy)
    else $error("soft reset length wrong");
  soft_clear_a: assert property ($rose(o_soft_reset_busy) |-> o_device_count == 3'h0 && o_dac_timing == 8'h00)
    else $error("soft reset left registers set");
  sync_pulse_a: assert property (o_frame_sync |=> !o_frame_sync[*8])
    else $error("frame sync too frequent");
  load_lead_a: assert property (o_dac_load && o_dac_timing[4:0] == 5'h00 |-> !o_frame_sync ##[1:40] o_frame_sync)
    else $error("dac load not one serial clock before sync");
  out_timing_a: assert property (o_out_valid |-> $past(o_sclk_fall))
    else $error("outgoing word not after serial clock edge");
  invalid_prog_a: assert property (o_invalid_word |-> $past(o_sclk_fall) && !$past(o_operating_mode))
    else $error("invalid flag outside program mode");
  sync_c: cover property (o_frame_sync);
  soft_c: cover property ($rose(o_soft_reset_busy));
  out_c: cover property (o_out_valid);
  inv_c: cover property (o_invalid_word);
endmodule
bind codec_control_word_clock_dividers codec_ctrl_asserts chk (.i_core_clk, .i_rst_n,
  .i_word_valid, .o_word_ready, .o_out_valid, .o_invalid_word, .o_device_master_clock_tick, .o_sclk_fall,
  .o_frame_sync, .o_dac_load, .o_operating_mode, .o_soft_reset_busy, .o_device_count,
  .o_dac_timing);
`default_nettype wire

// ### verification/host_dsp_model.sv
`timescale 1ns/1ps
`default_nettype none
// host serial side: one word at a time, idle bus shows a changed pattern
module host_dsp_model (
  input  wire logic                     i_core_clk,   // master clock
  input  wire logic                     i_word_ready, // block can take a word
  output logic                          o_word_valid, // word offered
  output codec_ctrl_pkg::control_word_t o_word        // word itself
);
  bit slow = 1'b0; // stall before each word
  initial begin
    o_word_valid = 1'b0;
    o_word = 16'h5A5A;
  end
  // held from a falling edge until a rising edge finds ready high
  task automatic send(input logic [15:0] w);
    int i;
    if (slow) repeat ($urandom_range(6, 1)) @(negedge i_core_clk);
    @(negedge i_core_clk);
    o_word_valid = 1'b1;
    o_word = w;
    i = 0;
    do begin @(posedge i_core_clk); i++; end while (!i_word_ready && i < 200);
    @(negedge i_core_clk);
    o_word_valid = 1'b0;
    o_word = ~w; // no stale word left on the bus
  endtask
endmodule
`default_nettype wire

// ### verification/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic                          i_core_clk = 1'b0; // 40 MHz
  logic                          i_rst_n = 1'b0;    // reset pin
  logic                          i_word_valid;      // from host
  codec_ctrl_pkg::control_word_t i_word;            // from host
  logic        o_word_ready, o_out_valid, o_dac_valid, o_invalid_word, o_device_master_clock_tick;
  logic        o_sclk_fall, o_frame_sync, o_dac_load, o_operating_mode, o_mixed_mode;
  logic        o_digital_loopback, o_port_loopback, o_soft_reset_busy;
  logic [2:0]  o_device_count;
  logic [7:0]  o_power_control, o_gain_select, o_dac_timing, o_analog_tap;
  logic [15:0] o_out_word, o_dac_word, o_digital_tap, got_out, got_dac;
  logic        got_inv;                             // seen responses
  int          mismatches, num_checks, mreg[8], c, l, m, r, busy_n;
  always #12.5 i_core_clk = ~i_core_clk;
  codec_control_word_clock_dividers DUT (.i_core_clk, .i_rst_n, .i_word_valid, .i_word,
    .o_word_ready, .o_out_valid, .o_out_word, .o_dac_valid, .o_dac_word, .o_invalid_word,
    .o_device_master_clock_tick, .o_sclk_fall, .o_frame_sync, .o_dac_load, .o_operating_mode, .o_mixed_mode,
    .o_digital_loopback, .o_port_loopback, .o_device_count, .o_soft_reset_busy,
    .o_power_control, .o_gain_select, .o_dac_timing, .o_analog_tap, .o_digital_tap);
  host_dsp_model host (.i_core_clk, .i_word_ready(o_word_ready), .o_word_valid(i_word_valid),
    .o_word(i_word));
  // catch one-cycle strobes
  always @(posedge i_core_clk) begin
    if (o_out_valid) got_out <= o_out_word;
    if (o_dac_valid) got_dac <= o_dac_word;
    if (o_invalid_word) got_inv <= 1'b1;
    if (o_soft_reset_busy) busy_n <= busy_n + 1;
  end
  task automatic chk(string n, logic [15:0] e, logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  // register outputs against the integer model
  task automatic regs();
    chk("mode bits", 16'(mreg[0] & 8'h7F), {9'h0, o_device_count, o_port_loopback,
      o_digital_loopback, o_mixed_mode, o_operating_mode});
    chk("reg 2 3", 16'(mreg[3] * 256 + mreg[2]), {o_gain_select, o_power_control});
    chk("reg 4 5", 16'(mreg[5] * 256 + mreg[4]), {o_analog_tap, o_dac_timing});
    chk("reg 6 7", 16'(mreg[7] * 256 + mreg[6]), o_digital_tap);
  endtask
  // send one word, wait for it to be applied, then model and compare
  task automatic word(logic [15:0] w);
    int i;
    logic dat;
    got_out = 'x;
    got_dac = 'x;
    got_inv = 1'b0;
    host.send(w);
    i = 0;
    while (!o_word_ready && i < 200) begin @(negedge i_core_clk); i++; end
    repeat (2) @(negedge i_core_clk);
    dat = mreg[0][0] && (!mreg[0][1] || !w[15]);
    if (dat) chk("dac word", mreg[0][1] ? {w[14:0], 1'b0} : w, got_dac);
    else if (!w[15]) chk("invalid flag", 16'h0001, {15'h0, got_inv});
    else if (w[13:11] != 3'h0) chk("forwarded", {w[15:14], w[13:11] - 3'h1, w[10:0]}, got_out);
    else if (w[14]) chk("read word", {w[15:8], 8'(mreg[w[10:8]])}, got_out);
    else if (w[10:8] == 3'h0 && w[7]) mreg = '{default: 0};
    else mreg[w[10:8]] = w[7:0];
    regs();
  endtask
  // pulse spacing in core cycles, second interval after syncing
  task automatic gap(int s, int e, string n);
    for (int k = 0; k < 2; k++) begin
      c = 0;
      do begin @(negedge i_core_clk); c++; end
      while (!(s == 0 ? o_device_master_clock_tick : s == 1 ? o_sclk_fall : o_frame_sync) && c < 20000);
    end
    chk(n, 16'(e), 16'(c));
  endtask
  // cycles to next frame sync, and where the last dac load fell
  task automatic sync_lead();
    c = 0;
    l = 0;
    do begin @(negedge i_core_clk); c++; if (o_dac_load) l = c; end
    while (!o_frame_sync && c < 5000);
  endtask
  task automatic complete_run();
    if (mismatches == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    void'($urandom(41919));
    mreg = '{default: 0};
    repeat (20) @(negedge i_core_clk);
    i_rst_n = 1'b1;
    regs();
    sync_lead();
    chk("first sync", 16'd2048, 16'(c));
    chk("load lead", 16'd8, 16'(c - l));
    gap(1, 8, "serial period");
    host.slow = 1'b1;
    for (r = 2; r < 8; r++) word({5'h10, 3'(r), 8'($urandom)});
    word({5'h10, 3'h0, 8'($urandom) & 8'h7C});
    for (r = 0; r < 8; r++) word({5'h18, 3'(r), 8'h00});
    for (r = 1; r < 8; r++) word({1'b1, r[0], 3'(r), 3'h2, 8'($urandom)});
    word(16'h1234);
    host.slow = 1'b0;
    for (r = 0; r < 8; r++) begin
      word({5'h10, 3'h1, 1'b0, 3'(r), r[1:0], r[1:0]});
      m = r <= 4 ? r + 1 : 1;
      gap(0, m, "master tick");
      gap(1, m * (8 >> r[1:0]), "serial period");
      gap(2, m * (2048 >> r[1:0]), "sample period");
    end
    busy_n = 0;
    word({5'h10, 3'h0, 8'h80});
    repeat (4) @(negedge i_core_clk);
    chk("reset length", 16'd4, 16'(busy_n));
    for (r = 0; r < 32; r += 31) begin
      word({5'h10, 3'h4, 8'(r)});
      sync_lead();
      sync_lead();
      chk("advanced lead", 16'(8 + r * 64), 16'(c - l));
    end
    word({5'h10, 3'h0, 8'h03});
    word(16'h1234);
    word({5'h10, 3'h0, 8'h01});
    word(16'h9ABC);
    @(negedge i_core_clk);
    i_rst_n = 1'b0;
    @(negedge i_core_clk);
    i_rst_n = 1'b1;
    mreg = '{default: 0};
    regs();
    sync_lead();
    chk("sync after reset", 16'd2048, 16'(c));
    word({5'h18, 3'h1, 8'h00});
    complete_run();
  end
  // hang guard well beyond the expected run length
  initial begin
    repeat (90000) @(posedge i_core_clk);
    mismatches++;
    complete_run();
  end
endmodule
`default_nettype wire
